// ---- rtl/ptc_regs.svh ----
// Timing and value constants of the timer and counter units
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH
`define PTC_CLK_PERIOD_NS 10
`define PTC_BASE_100MS_US 100000
`define PTC_BASE_10MS_US 10000
`define PTC_BASE_1MS_US 1000
`define PTC_US_TO_NS 1000
`define PTC_VAL_ZERO 16'h0000
`define PTC_VAL_ONE 16'h0001
`define PTC_VAL_MAX 16'hFFFF
`endif

// ---- rtl/ptc_pkg.sv ----
// Types shared by the timer and counter unit modules
package ptc_pkg;
  typedef enum logic [2:0] {
    TM_ON_DELAY = 3'h0,
    TM_OFF_DELAY = 3'h1,
    TM_ACCUM = 3'h2,
    TM_ONE_SHOT = 3'h3,
    TM_RETRIG = 3'h4
  } ptc_tmode_t;
  typedef enum logic [1:0] {
    TB_100MS = 2'h0,
    TB_10MS = 2'h1,
    TB_1MS = 2'h2
  } ptc_tbase_t;
  typedef enum logic [1:0] {
    CM_UP = 2'h0,
    CM_DOWN = 2'h1,
    CM_UPDOWN = 2'h2,
    CM_RING = 2'h3
  } ptc_cmode_t;
  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_RUN = 2'b01,
    TS_DONE = 2'b11
  } ptc_tstate_t;
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } ptc_tick_state_t;
  typedef struct packed {
    ptc_tstate_t tstate;
    logic [15:0] tcv;
    logic tcontact;
    logic [15:0] pend;
    logic [15:0] ccv;
    logic ccontact;
  } ptc_top_state_t;
endpackage : ptc_pkg

// ---- rtl/ptc_tick_gen.sv ----
// Time base tick generator dividing the system clock
module ptc_tick_gen
  import ptc_pkg::*;
#(
  parameter int unsigned DIV = 1000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic tick_out
);
  ptc_tick_state_t r;
  ptc_tick_state_t next_r;

  // Wrap the divider and pulse once per period
  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.cnt >= 32'(DIV - 1)) begin
      next_r.cnt = 32'h0000_0000;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick_out = r.tick;
endmodule : ptc_tick_gen

// ---- rtl/ptc_scan_edge.sv ----
// Off-to-on edge detector sampled once per scan end
module ptc_scan_edge
  import ptc_pkg::*;
#(
  parameter int unsigned W = 3
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sample_in,
  input wire logic [W-1:0] level_in,
  output logic [W-1:0] rise_out
);
  typedef struct packed {
    logic [W-1:0] prev;
  } ptc_edge_state_t;
  ptc_edge_state_t r;
  ptc_edge_state_t next_r;

  // Remember the level seen at the last scan end only
  always_comb begin
    next_r = r;
    if (sample_in) begin
      next_r.prev = level_in;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Edge seen only at a scan end, so steady levels never count
  assign rise_out = sample_in ? (level_in & ~r.prev) : '0;
endmodule : ptc_scan_edge

// ---- rtl/ptc_top.sv ----
// Timer and counter function units updated at each scan end
//
// Functional notes
// [RULE1] Three time bases: 100, 10, 1 ms
// [RULE2] On-delay counts up, contact at preset
// [RULE3] On-delay input low clears value
// [RULE4] Off-delay input high: contact on, load preset
// [RULE5] Off-delay counts down after release, reloads
// [RULE6] Accumulating timer holds value while input low
// [RULE7] Accumulating contact cleared only by reset
// [RULE8] One-shot: contact on, count down from preset
// [RULE9] Retrigger edge reloads preset during countdown
// [RULE10] Values and contacts change only at scan end
// [RULE11] Counters act on rising edges only
// [RULE12] Up counter increments, contact at preset
// [RULE13] Down counter decrements, contact at zero
// [RULE14] Up/down reset holds zero, contact off
// [RULE15] Up/down contact while value at/above preset
// [RULE16] Ring counter wraps to zero after preset
// [RULE17] Count inputs must last over one scan
// [RULE18] One-shot ignores input while counting
// [RULE19] Values are 16-bit counts of time base
`include "ptc_regs.svh"

module ptc_top
  import ptc_pkg::*;
#(
  parameter int unsigned BASE_100MS_CYC =
    `PTC_BASE_100MS_US * `PTC_US_TO_NS / `PTC_CLK_PERIOD_NS,
  parameter int unsigned BASE_10MS_CYC =
    `PTC_BASE_10MS_US * `PTC_US_TO_NS / `PTC_CLK_PERIOD_NS,
  parameter int unsigned BASE_1MS_CYC =
    `PTC_BASE_1MS_US * `PTC_US_TO_NS / `PTC_CLK_PERIOD_NS
) (
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  input wire logic SCAN_END_IN,
  input wire logic [2:0] TMR_MODE_IN,
  input wire logic [1:0] TIME_BASE_IN,
  input wire logic TMR_INPUT_IN,
  input wire logic TMR_RESET_IN,
  input wire logic [15:0] PRESET_TIME_IN,
  output logic [15:0] TMR_CURRENT_OUT,
  output logic TMR_CONTACT_OUT,
  input wire logic [1:0] CNT_MODE_IN,
  input wire logic CNT_UP_IN,
  input wire logic CNT_DOWN_IN,
  input wire logic CNT_RESET_IN,
  input wire logic [15:0] PRESET_VALUE_IN,
  output logic [15:0] CNT_CURRENT_OUT,
  output logic CNT_CONTACT_OUT
);

  // Saturating add capped at a limit
  function automatic logic [15:0] add_lim(
    input logic [15:0] a,
    input logic [15:0] b,
    input logic [15:0] lim
  );
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, lim}) begin
      add_lim = lim;
    end else begin
      add_lim = s[15:0];
    end
  endfunction : add_lim

  // Subtract that stops at zero
  function automatic logic [15:0] sub_sat(
    input logic [15:0] a,
    input logic [15:0] b
  );
    if (a > b) begin
      sub_sat = a - b;
    end else begin
      sub_sat = `PTC_VAL_ZERO;
    end
  endfunction : sub_sat

  ptc_top_state_t r;
  ptc_top_state_t next_r;
  logic tick_100;
  logic tick_10;
  logic tick_1;
  logic tick_sel;
  logic [2:0] rise;
  logic tmr_rise;
  logic cnt_up_rise;
  logic cnt_dn_rise;
  ptc_tmode_t tmode;
  ptc_cmode_t cmode;
  ptc_tbase_t tbase;

  assign tmode = ptc_tmode_t'(TMR_MODE_IN);
  assign cmode = ptc_cmode_t'(CNT_MODE_IN);
  assign tbase = ptc_tbase_t'(TIME_BASE_IN);

  // [RULE1] time base tick sources
  ptc_tick_gen #(
    .DIV(BASE_100MS_CYC)
  ) u_tick_100 (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .tick_out(tick_100)
  );

  ptc_tick_gen #(
    .DIV(BASE_10MS_CYC)
  ) u_tick_10 (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .tick_out(tick_10)
  );

  ptc_tick_gen #(
    .DIV(BASE_1MS_CYC)
  ) u_tick_1 (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .tick_out(tick_1)
  );

  // Pick the tick of the selected base; unused code gives no time
  always_comb begin
    case (tbase)
      TB_100MS: tick_sel = tick_100;
      TB_10MS: tick_sel = tick_10;
      TB_1MS: tick_sel = tick_1;
      default: tick_sel = 1'b0;
    endcase
  end

  // [RULE11] edges sampled scan to scan
  ptc_scan_edge #(
    .W(3)
  ) u_edge (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .sample_in(SCAN_END_IN),
    .level_in({CNT_DOWN_IN, CNT_UP_IN, TMR_INPUT_IN}),
    .rise_out(rise)
  );

  assign tmr_rise = rise[0];
  assign cnt_up_rise = rise[1];
  assign cnt_dn_rise = rise[2];

  // Next-state logic for both units
  always_comb begin
    logic [15:0] el;
    logic [15:0] v;
    el = r.pend;
    v = `PTC_VAL_ZERO;
    next_r = r;

    // Elapsed base units since last scan end; a tick on the
    // scan end itself is kept for the next scan, not lost
    if (SCAN_END_IN) begin
      next_r.pend = tick_sel ? `PTC_VAL_ONE : `PTC_VAL_ZERO;
    end else if (tick_sel && (r.pend != `PTC_VAL_MAX)) begin
      next_r.pend = r.pend + `PTC_VAL_ONE;
    end

    // [RULE10] timer moves at scan end
    if (SCAN_END_IN) begin
      if (TMR_RESET_IN) begin
        // [RULE7] reset clears value, contact
        next_r.tcv = `PTC_VAL_ZERO;
        next_r.tcontact = 1'b0;
        next_r.tstate = TS_IDLE;
      end else begin
        case (tmode)
          TM_ON_DELAY: begin
            if (TMR_INPUT_IN) begin
              // [RULE2] count up to preset
              v = add_lim(r.tcv, el, PRESET_TIME_IN);
              next_r.tcv = v;
              next_r.tcontact = (v == PRESET_TIME_IN);
              next_r.tstate = (v == PRESET_TIME_IN) ? TS_DONE : TS_RUN;
            end else begin
              // [RULE3] clear on release
              next_r.tcv = `PTC_VAL_ZERO;
              next_r.tcontact = 1'b0;
              next_r.tstate = TS_IDLE;
            end
          end
          TM_OFF_DELAY: begin
            if (TMR_INPUT_IN) begin
              // [RULE4] hold preset, contact on
              next_r.tcv = PRESET_TIME_IN;
              next_r.tcontact = 1'b1;
              next_r.tstate = TS_DONE;
            end else if (r.tcontact) begin
              // [RULE5] count down to zero
              v = sub_sat(r.tcv, el);
              next_r.tcv = v;
              next_r.tstate = TS_RUN;
              if (v == `PTC_VAL_ZERO) begin
                next_r.tcontact = 1'b0;
                next_r.tstate = TS_IDLE;
              end
            end
          end
          TM_ACCUM: begin
            // [RULE6] advance only while input on
            if (TMR_INPUT_IN) begin
              v = add_lim(r.tcv, el, PRESET_TIME_IN);
              next_r.tcv = v;
              next_r.tstate = TS_RUN;
              if (v == PRESET_TIME_IN) begin
                // [RULE7] sticky until reset
                next_r.tcontact = 1'b1;
                next_r.tstate = TS_DONE;
              end
            end
          end
          TM_ONE_SHOT: begin
            if (r.tstate == TS_RUN) begin
              // [RULE18] input ignored while running
              v = sub_sat(r.tcv, el);
              next_r.tcv = v;
              if (v == `PTC_VAL_ZERO) begin
                next_r.tcontact = 1'b0;
                next_r.tstate = TS_IDLE;
              end
            end else if (tmr_rise && (PRESET_TIME_IN != `PTC_VAL_ZERO)) begin
              // [RULE8] start pulse from preset
              next_r.tcv = PRESET_TIME_IN;
              next_r.tcontact = 1'b1;
              next_r.tstate = TS_RUN;
            end
          end
          TM_RETRIG: begin
            if (tmr_rise && (PRESET_TIME_IN != `PTC_VAL_ZERO)) begin
              // [RULE9] reload on each new edge
              next_r.tcv = PRESET_TIME_IN;
              next_r.tcontact = 1'b1;
              next_r.tstate = TS_RUN;
            end else if (r.tstate == TS_RUN) begin
              // [RULE8] count down, end at zero
              v = sub_sat(r.tcv, el);
              next_r.tcv = v;
              if (v == `PTC_VAL_ZERO) begin
                next_r.tcontact = 1'b0;
                next_r.tstate = TS_IDLE;
              end
            end
          end
          default: begin
            // Undefined mode freezes the timer
            next_r.tstate = r.tstate;
          end
        endcase
      end
    end

    // [RULE10] counter moves at scan end
    if (SCAN_END_IN) begin
      case (cmode)
        CM_UP: begin
          if (CNT_RESET_IN) begin
            // [RULE14] held at zero in reset
            next_r.ccv = `PTC_VAL_ZERO;
            next_r.ccontact = 1'b0;
          end else if (cnt_up_rise) begin
            // [RULE12] increment, contact at preset
            v = add_lim(r.ccv, `PTC_VAL_ONE, `PTC_VAL_MAX);
            next_r.ccv = v;
            if (v == PRESET_VALUE_IN) begin
              next_r.ccontact = 1'b1;
            end
          end
        end
        CM_DOWN: begin
          if (CNT_RESET_IN) begin
            // [RULE14] held at zero in reset
            next_r.ccv = `PTC_VAL_ZERO;
            next_r.ccontact = 1'b0;
          end else if (cnt_dn_rise && (r.ccv != `PTC_VAL_ZERO)) begin
            // [RULE13] decrement, contact at zero
            v = r.ccv - `PTC_VAL_ONE;
            next_r.ccv = v;
            if (v == `PTC_VAL_ZERO) begin
              next_r.ccontact = 1'b1;
            end
          end
        end
        CM_UPDOWN: begin
          v = r.ccv;
          if (CNT_RESET_IN) begin
            v = `PTC_VAL_ZERO;
          end else if (cnt_up_rise && !cnt_dn_rise) begin
            v = add_lim(r.ccv, `PTC_VAL_ONE, `PTC_VAL_MAX);
          end else if (cnt_dn_rise && !cnt_up_rise) begin
            v = sub_sat(r.ccv, `PTC_VAL_ONE);
          end
          // [RULE15] contact while at or above preset
          next_r.ccv = v;
          next_r.ccontact = (v >= PRESET_VALUE_IN);
        end
        CM_RING: begin
          if (CNT_RESET_IN) begin
            // [RULE16] reset zeroes value, contact
            next_r.ccv = `PTC_VAL_ZERO;
            next_r.ccontact = 1'b0;
          end else if (cnt_up_rise) begin
            // [RULE16] wrap after reaching preset
            if (r.ccv >= PRESET_VALUE_IN) begin
              v = `PTC_VAL_ZERO;
            end else begin
              v = r.ccv + `PTC_VAL_ONE;
            end
            next_r.ccv = v;
            next_r.ccontact = (v == PRESET_VALUE_IN);
          end
        end
        default: begin
          next_r.ccv = r.ccv;
        end
      endcase
    end
  end

  // State register; system reset clears both units
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // [RULE19] 16-bit values straight from flops
  assign TMR_CURRENT_OUT = r.tcv;
  assign TMR_CONTACT_OUT = r.tcontact;
  assign CNT_CURRENT_OUT = r.ccv;
  assign CNT_CONTACT_OUT = r.ccontact;
endmodule : ptc_top

// ---- dv/ptc_scan_model.sv ----
// Scan-end strobe source standing in for the user program scan
module ptc_scan_model #(
  parameter int unsigned SCAN_CYC = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic scan_end_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  // fixed scan period
  // A steady period keeps the elapsed base ticks per scan exact
  always_ff @(posedge clk_in) begin
    if (rst_in || cnt == 8'(SCAN_CYC - 1)) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
    scan_end_out <= !rst_in && cnt == 8'(SCAN_CYC - 1);
  end
endmodule : ptc_scan_model

// ---- dv/ptc_top_sva.sv ----
// Port assertions for the timer and counter units, bound to ptc_top
module ptc_top_sva
  import ptc_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  input wire logic SCAN_END_IN,
  input wire logic [2:0] TMR_MODE_IN,
  input wire logic TMR_INPUT_IN,
  input wire logic TMR_RESET_IN,
  input wire logic [15:0] PRESET_TIME_IN,
  input wire logic [15:0] TMR_CURRENT_OUT,
  input wire logic TMR_CONTACT_OUT,
  input wire logic [1:0] CNT_MODE_IN,
  input wire logic CNT_RESET_IN,
  input wire logic [15:0] PRESET_VALUE_IN,
  input wire logic [15:0] CNT_CURRENT_OUT,
  input wire logic CNT_CONTACT_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  // Timer properties
  property p_tmr_hold;
    !SCAN_END_IN |=> $stable(TMR_CURRENT_OUT) && $stable(TMR_CONTACT_OUT);
  endproperty
  property p_on_clear;
    SCAN_END_IN && TMR_MODE_IN == TM_ON_DELAY && !TMR_INPUT_IN
      |=> TMR_CURRENT_OUT == 16'h0000 && !TMR_CONTACT_OUT;
  endproperty
  property p_off_load;
    SCAN_END_IN && TMR_MODE_IN == TM_OFF_DELAY && TMR_INPUT_IN && !TMR_RESET_IN
      |=> TMR_CURRENT_OUT == $past(PRESET_TIME_IN) && TMR_CONTACT_OUT;
  endproperty
  property p_acc_keep;
    TMR_MODE_IN == TM_ACCUM && TMR_CONTACT_OUT && !(SCAN_END_IN && TMR_RESET_IN)
      |=> TMR_CONTACT_OUT;
  endproperty
  property p_tmr_rst;
    SCAN_END_IN && TMR_RESET_IN |=> TMR_CURRENT_OUT == 16'h0000 && !TMR_CONTACT_OUT;
  endproperty
  // Counter properties
  property p_cnt_rst;
    SCAN_END_IN && CNT_RESET_IN && (CNT_MODE_IN == CM_UP || CNT_MODE_IN == CM_DOWN)
      |=> CNT_CURRENT_OUT == 16'h0000 && !CNT_CONTACT_OUT;
  endproperty
  property p_ud_contact;
    SCAN_END_IN && CNT_MODE_IN == CM_UPDOWN
      |=> CNT_CONTACT_OUT == (CNT_CURRENT_OUT >= $past(PRESET_VALUE_IN));
  endproperty
  property p_ring_contact;
    SCAN_END_IN && CNT_MODE_IN == CM_RING && !CNT_RESET_IN
      |=> CNT_CONTACT_OUT == (CNT_CURRENT_OUT == $past(PRESET_VALUE_IN));
  endproperty

  a_tmr_hold: assert property (p_tmr_hold)
    else $error("timer outputs moved between scans");
  a_on_clear: assert property (p_on_clear)
    else $error("on-delay not cleared on low input");
  a_off_load: assert property (p_off_load)
    else $error("off-delay did not load preset");
  a_acc_keep: assert property (p_acc_keep)
    else $error("accumulating contact dropped without reset");
  a_tmr_rst: assert property (p_tmr_rst)
    else $error("timer reset did not clear");
  a_cnt_rst: assert property (p_cnt_rst)
    else $error("counter reset did not clear");
  a_ud_contact: assert property (p_ud_contact)
    else $error("up/down contact wrong");
  a_ring_contact: assert property (p_ring_contact)
    else $error("ring contact wrong");

  // Main scenarios reached
  c_acc_rst: cover property (SCAN_END_IN && TMR_RESET_IN && TMR_CONTACT_OUT);
  c_ring_wrap: cover property (CNT_MODE_IN == CM_RING && $fell(CNT_CONTACT_OUT));
  c_off_done: cover property (TMR_MODE_IN == TM_OFF_DELAY && $fell(TMR_CONTACT_OUT));
endmodule : ptc_top_sva

bind ptc_top ptc_top_sva u_ptc_top_sva (.CLOCK_IN, .SYS_RST_IN, .SCAN_END_IN,
  .TMR_MODE_IN, .TMR_INPUT_IN, .TMR_RESET_IN, .PRESET_TIME_IN, .TMR_CURRENT_OUT,
  .TMR_CONTACT_OUT, .CNT_MODE_IN, .CNT_RESET_IN, .PRESET_VALUE_IN, .CNT_CURRENT_OUT,
  .CNT_CONTACT_OUT);

// ---- dv/tb.sv ----
// Self-checking testbench for the timer and counter units
module tb;
  import ptc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic hi = 1'h1;
  localparam logic lo = 1'h0;
  logic clk, rst, scan, tin, trst, cup, cdn, crst, tcon, ccon;
  logic [2:0] tmode;
  logic [1:0] tbase, cmode;
  logic [15:0] pt, pv, tcur, ccur;
  int error_cnt = 0;
  int n_compared = 0;

  // Short base periods keep the run small; one 8-cycle scan sees 8/DIV ticks
  ptc_top #(.BASE_100MS_CYC(8), .BASE_10MS_CYC(4), .BASE_1MS_CYC(2)) u_ptc_top (
    .CLOCK_IN(clk), .SYS_RST_IN(rst), .SCAN_END_IN(scan), .TMR_MODE_IN(tmode),
    .TIME_BASE_IN(tbase), .TMR_INPUT_IN(tin), .TMR_RESET_IN(trst),
    .PRESET_TIME_IN(pt), .TMR_CURRENT_OUT(tcur), .TMR_CONTACT_OUT(tcon),
    .CNT_MODE_IN(cmode), .CNT_UP_IN(cup), .CNT_DOWN_IN(cdn), .CNT_RESET_IN(crst),
    .PRESET_VALUE_IN(pv), .CNT_CURRENT_OUT(ccur), .CNT_CONTACT_OUT(ccon));
  ptc_scan_model #(.SCAN_CYC(8)) u_ptc_scan_model (.clk_in(clk), .rst_in(rst),
    .scan_end_out(scan));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One scan: inputs held from just after an edge through the strobe edge
  task automatic step(input logic ti, tr, cu, cd, cr);
    int k;
    @(posedge clk);
    tin <= ti;
    trst <= tr;
    cup <= cu;
    cdn <= cd;
    crst <= cr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (scan !== 1'h1 && k < 20);
    if (k >= 20) begin
      error_cnt++;
      give_verdict();
    end
    @(negedge clk);
  endtask : step

  task automatic ts(input logic ti, tr, input logic [15:0] ec, input logic ek);
    step(ti, tr, lo, lo, lo);
    chk("tmr_current", tcur, ec);
    chk("tmr_contact", 16'(tcon), 16'(ek));
  endtask : ts

  task automatic cs(input logic cu, cd, cr, input logic [15:0] ec, input logic ek);
    step(lo, lo, cu, cd, cr);
    chk("cnt_current", ccur, ec);
    chk("cnt_contact", 16'(ccon), 16'(ek));
  endtask : cs

  task automatic setup(input logic [2:0] m, input logic [1:0] b, input logic [15:0] p);
    @(posedge clk);
    tmode <= m;
    tbase <= b;
    pt <= p;
  endtask : setup

  // On-delay per base: each scan adds per ticks, preset is three scans
  task automatic t_on(input logic [1:0] b, input logic [15:0] per);
    int i;
    setup(TM_ON_DELAY, b, per * 16'h0003);
    ts(lo, hi, 0, lo);
    ts(hi, lo, per, lo);
    ts(lo, lo, 0, lo);
    for (i = 1; i <= 3; i++) begin
      ts(hi, lo, per * i[15:0], i == 3);
    end
    ts(lo, lo, 0, lo);
    $display("on-delay base %0d done", b);
  endtask : t_on

  task automatic t_off();
    setup(TM_OFF_DELAY, TB_100MS, 16'h0003);
    ts(lo, hi, 0, lo);
    ts(hi, lo, 3, hi);
    ts(lo, lo, 2, hi);
    ts(hi, lo, 3, hi);
    ts(lo, lo, 2, hi);
    ts(lo, lo, 1, hi);
    ts(lo, lo, 0, lo);
    $display("off-delay done");
  endtask : t_off

  // Program-issued reset is the only way out of the accumulated state
  task automatic t_acc();
    setup(TM_ACCUM, TB_100MS, 16'h0003);
    ts(lo, hi, 0, lo);
    ts(hi, lo, 1, lo);
    ts(hi, lo, 2, lo);
    ts(lo, lo, 2, lo);
    ts(hi, lo, 3, hi);
    ts(lo, lo, 3, hi);
    ts(lo, hi, 0, lo);
    $display("accumulating done");
  endtask : t_acc

  // A second rising edge mid-pulse is ignored or reloads, by mode
  task automatic t_pulse(input logic rtg);
    setup(rtg ? TM_RETRIG : TM_ONE_SHOT, TB_100MS, 16'h0003);
    ts(lo, hi, 0, lo);
    ts(hi, lo, 3, hi);
    ts(lo, lo, 2, hi);
    ts(hi, lo, rtg ? 3 : 1, hi);
    ts(hi, lo, rtg ? 2 : 0, rtg);
    $display("pulse timer retrigger=%0d done", rtg);
  endtask : t_pulse

  task automatic t_cnt();
    cmode <= CM_UP;
    cs(lo, lo, hi, 0, lo);
    cs(hi, lo, lo, 1, lo);
    cs(hi, lo, lo, 1, lo);
    cs(lo, lo, lo, 1, lo);
    cs(hi, lo, lo, 2, hi);
    cs(hi, lo, hi, 0, lo);
    cs(lo, lo, lo, 0, lo);
    cs(hi, lo, lo, 1, lo);
    // Down counting needs a nonzero start, carried over from up mode
    cmode <= CM_DOWN;
    cs(lo, hi, lo, 0, hi);
    cs(lo, lo, hi, 0, lo);
    cs(lo, hi, lo, 0, lo);
    cs(lo, lo, lo, 0, lo);
    cmode <= CM_UPDOWN;
    cs(lo, lo, hi, 0, lo);
    cs(hi, lo, lo, 1, lo);
    cs(lo, lo, lo, 1, lo);
    cs(hi, lo, lo, 2, hi);
    cs(lo, hi, lo, 1, lo);
    cs(lo, lo, lo, 1, lo);
    cs(hi, hi, lo, 1, lo);
    cs(hi, hi, hi, 0, lo);
    cmode <= CM_RING;
    cs(lo, lo, lo, 0, lo);
    cs(hi, lo, lo, 1, lo);
    cs(lo, lo, lo, 1, lo);
    cs(hi, lo, lo, 2, hi);
    cs(lo, lo, lo, 2, hi);
    cs(hi, lo, lo, 0, lo);
    cs(lo, lo, lo, 0, lo);
    cs(hi, lo, lo, 1, lo);
    cs(lo, lo, hi, 0, lo);
    $display("counters done");
  endtask : t_cnt

  // Main sequence
  initial begin
    rst = 1'h1;
    tmode = TM_ON_DELAY;
    tbase = TB_100MS;
    cmode = CM_UP;
    {tin, trst, cup, cdn, crst} = 5'h00;
    pt = 16'h0000;
    pv = 16'h0002;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    t_on(TB_100MS, 16'h0001);
    t_on(TB_10MS, 16'h0002);
    t_on(TB_1MS, 16'h0004);
    t_off();
    t_acc();
    t_pulse(lo);
    t_pulse(hi);
    t_cnt();
    give_verdict();
  end
endmodule : tb
